/* include/serial_port_pkg.sv */
// constants, encodings and pin carriers for the serial port block
package serial_port_pkg;
  // register byte addresses on the wishbone slave
  localparam logic [3:0] ADDR_CTRL_A = 4'h0;
  localparam logic [3:0] ADDR_CTRL_B = 4'h4;
  localparam logic [3:0] ADDR_DATA = 4'h8;
  // serial_port_control_a field positions
  localparam int CA_MODE_MSB = 7;
  localparam int CA_MODE_LSB = 5;
  localparam int CA_ENABLE = 1;
  localparam int CA_INCOMPLETE = 0;
  // serial_port_control_b field positions
  localparam int CB_POLARITY = 5;
  localparam int CB_EDGE = 4;
  localparam int CB_ORDER = 3;
  localparam int CB_SEL_EN = 2;
  localparam int CB_COLLISION = 1;
  localparam int CB_COMPLETE = 0;
  // port_mode_select encodings
  localparam logic [2:0] MODE_DIV4 = 3'h0;
  localparam logic [2:0] MODE_DIV16 = 3'h1;
  localparam logic [2:0] MODE_DIV64 = 3'h2;
  localparam logic [2:0] MODE_SUB = 3'h3;
  localparam logic [2:0] MODE_TIMER = 3'h4;
  localparam logic [2:0] MODE_SLAVE = 3'h5;
  localparam logic [1:0] MODE_OFF_TOP = 2'h3;
  // values after reset
  localparam logic [2:0] MODE_RESET = 3'h7;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // half shift-clock periods in system clock cycles
  localparam logic [5:0] HALF_DIV4 = 6'h02;
  localparam logic [5:0] HALF_DIV16 = 6'h08;
  localparam logic [5:0] HALF_DIV64 = 6'h20;
  // clock edges and bits of one byte
  localparam logic [3:0] LAST_EDGE = 4'hF;
  localparam logic [2:0] LAST_BIT = 3'h7;
  // transfer engine states
  typedef enum logic [1:0] {XF_IDLE, XF_MASTER, XF_SLAVE} xfer_e;
  // levels sensed on the port pins
  typedef struct packed {
    logic sck;
    logic sdi;
    logic sel_n;
  } pin_in_s;
  // drive and function ownership of the port pins
  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic sdo;
    logic sdo_oe;
    logic sdi_func;
    logic sel_func;
  } pin_out_s;
endpackage

/* src/serial_port.sv */
// serial master/slave port with wishbone register access
//
// The register addresses and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ns
module serial_port
  import serial_port_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // master clock sources
  input wire logic sub_clk_i,
  input wire logic timer_match_i,
  // port pins
  input wire pin_in_s pins_i,
  output pin_out_s pins_o
);
  // register state
  logic [2:0] mode, next_mode;
  logic enable, next_enable;
  logic incomplete, next_incomplete;
  logic polarity, next_polarity;
  logic edge_sel, next_edge_sel;
  logic order, next_order;
  logic sel_en, next_sel_en;
  logic collision, next_collision;
  logic complete, next_complete;
  logic [7:0] data, next_data;
  // transfer engine state
  xfer_e state, next_state;
  logic [7:0] tx, next_tx;
  logic [7:0] rx, next_rx;
  logic [3:0] edge_cnt, next_edge_cnt;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic captured, next_captured;
  logic [5:0] div_cnt, next_div_cnt;
  logic sck_q, next_sck_q;
  logic sck_in_q, next_sck_in_q;
  logic sub_q, next_sub_q;
  // bus answer state
  logic ack, next_ack;
  logic [31:0] rdata, next_rdata;

  // decoded controls and events
  logic port_on, is_slave, is_master, selected, cap_rising, tick;
  logic [5:0] half_lim;
  // write strobes
  logic req, wr_a, wr_b, wr_d;
  // serial edge events
  logic ev, ev_rise, ev_cap, tx_bit;
  // received byte after this capture
  logic [7:0] rx_new;
  // flag set requests
  logic set_complete, set_incomplete, set_collision;

  // mode decode and clock source selection
  always_comb begin
    port_on = enable && (mode[2:1] != MODE_OFF_TOP);
    is_slave = (mode == MODE_SLAVE);
    is_master = port_on && !is_slave;
    selected = !sel_en || !pins_i.sel_n;
    cap_rising = (polarity == edge_sel);
    tx_bit = order ? tx[7] : tx[0];
    half_lim = HALF_DIV4;
    tick = 1'b0;
    case (mode)
      MODE_DIV4: begin
        half_lim = HALF_DIV4;
        tick = (div_cnt == half_lim - 6'h01);
      end
      MODE_DIV16: begin
        half_lim = HALF_DIV16;
        tick = (div_cnt == half_lim - 6'h01);
      end
      MODE_DIV64: begin
        half_lim = HALF_DIV64;
        tick = (div_cnt == half_lim - 6'h01);
      end
      // sub clock: every change of level is half a shift period
      MODE_SUB: begin
        tick = (sub_clk_i != sub_q);
      end
      // timer: every match pulse is half a shift period
      MODE_TIMER: begin
        tick = timer_match_i;
      end
      // slave and off modes make no master clock
      default: begin
        tick = 1'b0;
      end
    endcase
  end

  // bus decode and serial clock edge classification
  always_comb begin
    req = cyc_i && stb_i && !ack;
    // register write strobes, low byte lane only
    wr_a = req && we_i && sel_i[0] && (adr_i == ADDR_CTRL_A);
    wr_b = req && we_i && sel_i[0] && (adr_i == ADDR_CTRL_B);
    wr_d = req && we_i && sel_i[0] && (adr_i == ADDR_DATA);
    if (is_master) begin
      // master edges come from its selected clock source
      ev = (state == XF_MASTER) && tick;
      ev_rise = !sck_q;
    end else begin
      // slave edges are changes of the clock pin level
      ev = port_on && selected && (pins_i.sck != sck_in_q);
      ev_rise = pins_i.sck;
    end
    ev_cap = (ev_rise == cap_rising);
    rx_new = order ? {rx[6:0], pins_i.sdi} : {pins_i.sdi, rx[7:1]};
  end

  // next values of registers, flags and transfer engine
  always_comb begin
    next_mode = mode;
    next_enable = enable;
    next_polarity = polarity;
    next_edge_sel = edge_sel;
    next_order = order;
    next_sel_en = sel_en;
    next_data = data;
    next_state = state;
    next_tx = tx;
    next_rx = rx;
    next_edge_cnt = edge_cnt;
    next_bit_cnt = bit_cnt;
    next_captured = captured;
    next_div_cnt = div_cnt;
    next_sck_q = sck_q;
    // pin and source levels of the previous cycle for edge detection
    next_sck_in_q = pins_i.sck;
    next_sub_q = sub_clk_i;
    set_complete = 1'b0;
    set_incomplete = 1'b0;
    set_collision = 1'b0;
    // control writes; unimplemented bits are not stored
    if (wr_a) begin
      next_mode = dat_i[CA_MODE_MSB:CA_MODE_LSB];
      next_enable = dat_i[CA_ENABLE];
    end
    if (wr_b) begin
      next_polarity = dat_i[CB_POLARITY];
      next_edge_sel = dat_i[CB_EDGE];
      next_order = dat_i[CB_ORDER];
      next_sel_en = dat_i[CB_SEL_EN];
    end
    // data write: load when idle, drop and flag when busy
    if (wr_d) begin
      if (state != XF_IDLE) begin
        set_collision = 1'b1;
      end else begin
        next_data = dat_i[7:0];
        next_tx = dat_i[7:0];
        if (is_master) begin
          next_state = XF_MASTER;
          next_edge_cnt = 4'h0;
          next_bit_cnt = 3'h0;
          next_captured = 1'b0;
          next_div_cnt = 6'h00;
        end
      end
    end
    // master divider runs only during a transfer
    if (state == XF_MASTER) begin
      next_div_cnt = tick ? 6'h00 : div_cnt + 6'h01;
    end
    // one clock edge of the byte, master or slave
    if (ev) begin
      if (is_master) begin
        next_sck_q = !sck_q;
        next_edge_cnt = edge_cnt + 4'h1;
      end else begin
        next_state = XF_SLAVE;
      end
      if (ev_cap) begin
        next_rx = rx_new;
        next_bit_cnt = bit_cnt + 3'h1;
        next_captured = 1'b1;
      end else if (captured) begin
        next_tx = order ? {tx[6:0], 1'b0} : {1'b0, tx[7:1]};
      end
      // byte end: master after last edge, slave after eighth capture
      if ((is_master && edge_cnt == LAST_EDGE) ||
          (!is_master && ev_cap && bit_cnt == LAST_BIT)) begin
        next_data = ev_cap ? rx_new : rx;
        set_complete = 1'b1;
        next_state = XF_IDLE;
        next_bit_cnt = 3'h0;
        next_captured = 1'b0;
        next_edge_cnt = 4'h0;
      end
    end
    // slave released mid byte by the select line
    if (state == XF_SLAVE && is_slave && port_on && sel_en && pins_i.sel_n) begin
      set_incomplete = 1'b1;
      set_complete = 1'b1;
      next_state = XF_IDLE;
      next_bit_cnt = 3'h0;
      next_captured = 1'b0;
    end
    // disabled port or idle master: hold engine quiet, clock at idle level
    if (!port_on) begin
      next_state = XF_IDLE;
      next_bit_cnt = 3'h0;
      next_captured = 1'b0;
      next_edge_cnt = 4'h0;
      next_div_cnt = 6'h00;
    end
    if (!port_on || state != XF_MASTER) begin
      next_sck_q = !next_polarity;
    end
    // sticky flags: hardware set wins over a software write
    next_incomplete = incomplete;
    next_collision = collision;
    next_complete = complete;
    // software writes put the written value in place
    if (wr_a) begin
      next_incomplete = dat_i[CA_INCOMPLETE];
    end
    if (wr_b) begin
      next_collision = dat_i[CB_COLLISION];
      next_complete = dat_i[CB_COMPLETE];
    end
    // hardware events come last so they win in a shared cycle
    if (set_incomplete) begin
      next_incomplete = 1'b1;
    end
    if (set_collision) begin
      next_collision = 1'b1;
    end
    if (set_complete) begin
      next_complete = 1'b1;
    end
  end

  // bus answer: one cycle after the request, read data registered
  always_comb begin
    next_ack = req;
    next_rdata = rdata;
    if (req) begin
      case (adr_i)
        // control a: mode, enable, incomplete; bits 4..2 read zero
        ADDR_CTRL_A: begin
          next_rdata = {24'h000000, mode, 3'h0, enable, incomplete};
        end
        // control b: bits 7..6 read zero
        ADDR_CTRL_B: begin
          next_rdata = {24'h000000, 2'h0, polarity, edge_sel, order, sel_en,
                        collision, complete};
        end
        // data register: last byte written or received
        ADDR_DATA: begin
          next_rdata = {24'h000000, data};
        end
        // unmapped addresses read zero
        default: begin
          next_rdata = 32'h00000000;
        end
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // control fields and flags
      mode <= MODE_RESET;
      enable <= 1'b0;
      incomplete <= 1'b0;
      polarity <= 1'b0;
      edge_sel <= 1'b0;
      order <= 1'b0;
      sel_en <= 1'b0;
      collision <= 1'b0;
      complete <= 1'b0;
      data <= DATA_RESET;
      // transfer engine
      state <= XF_IDLE;
      tx <= DATA_RESET;
      rx <= DATA_RESET;
      edge_cnt <= 4'h0;
      bit_cnt <= 3'h0;
      captured <= 1'b0;
      div_cnt <= 6'h00;
      // pin and source level history
      sck_q <= 1'b1;
      sck_in_q <= 1'b0;
      sub_q <= 1'b0;
      // bus answer
      ack <= 1'b0;
      rdata <= 32'h00000000;
    end else begin
      // control fields and flags
      mode <= next_mode;
      enable <= next_enable;
      incomplete <= next_incomplete;
      polarity <= next_polarity;
      edge_sel <= next_edge_sel;
      order <= next_order;
      sel_en <= next_sel_en;
      collision <= next_collision;
      complete <= next_complete;
      data <= next_data;
      // transfer engine
      state <= next_state;
      tx <= next_tx;
      rx <= next_rx;
      edge_cnt <= next_edge_cnt;
      bit_cnt <= next_bit_cnt;
      captured <= next_captured;
      div_cnt <= next_div_cnt;
      // pin and source level history
      sck_q <= next_sck_q;
      sck_in_q <= next_sck_in_q;
      sub_q <= next_sub_q;
      // bus answer
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  // pin drive and ownership
  always_comb begin
    // master drives the clock at its idle level between bytes
    pins_o.sck = 1'b0;
    pins_o.sck_oe = 1'b0;
    if (is_master) begin
      pins_o.sck = sck_q;
      pins_o.sck_oe = 1'b1;
    end
    // data out: high while master idles, else the current transmit bit
    if (is_master && state != XF_MASTER) begin
      pins_o.sdo = 1'b1;
    end else begin
      pins_o.sdo = tx_bit;
    end
    // data out released by a deselected slave
    pins_o.sdo_oe = port_on && (is_master || selected);
    // pin function ownership
    pins_o.sdi_func = port_on;
    pins_o.sel_func = port_on && sel_en;
  end

  // bus outputs
  assign ack_o = ack;
  assign dat_o = rdata;
endmodule

/* verif/serial_far_model.sv */
// far-side serial device answering the port in master mode
`timescale 1ns/1ns
module serial_far_model (
  // clock and byte load
  input wire logic clk_i,
  input wire logic load_i,
  input wire logic [7:0] tx_i,
  // link settings
  input wire logic pol_i,
  input wire logic edge_i,
  input wire logic order_i,
  // serial lines
  input wire logic sck_i,
  input wire logic sck_oe_i,
  input wire logic sdo_i,
  output logic sdi_o,
  output logic [7:0] rx_o
);
  logic last;
  logic prev_sdo;
  logic [3:0] caps;
  logic [2:0] idx;
  // capture on the active edge, shift on the other one after a capture
  always @(posedge clk_i) begin
    if (load_i) begin
      caps <= 4'h0;
      idx <= 3'h0;
    end else if (sck_oe_i && sck_i != last) begin
      if (sck_i == (pol_i ~^ edge_i)) begin
        // the port may leave its last bit at the capture edge, so use the level before it
        rx_o <= {rx_o[6:0], prev_sdo};
        caps <= caps + 4'h1;
      end else if (caps != 4'h0) begin
        idx <= idx + 3'h1;
      end
    end
    last <= sck_i;
    prev_sdo <= sdo_i;
  end
  // current bit, inverted once the byte is over so stale data never matches
  assign sdi_o = (caps == 4'h8) ^ tx_i[order_i ? 3'h7 - idx : idx];
endmodule

/* verif/serial_port_checker.sv */
// port-level assertions for the serial port block
`timescale 1ns/1ns
module serial_port_checker
  import serial_port_pkg::*;
(
  // clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // port pins
  input wire pin_in_s pins_i,
  input wire pin_out_s pins_o
);
  logic en;
  logic selen;
  logic [2:0] mode;
  wire logic wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // shadow of the control bits taken over the bus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode <= MODE_RESET;
      en <= 1'b0;
      selen <= 1'b0;
    end else if (wr && adr_i == ADDR_CTRL_A) begin
      mode <= dat_i[7:5];
      en <= dat_i[1];
    end else if (wr && adr_i == ADDR_CTRL_B) begin
      selen <= dat_i[2];
    end
  end
  property p_ack; ack_o |=> !ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack held too long");
  property p_take; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_take: assert property (p_take) else $error("request not answered");
  property p_hi; dat_o[31:8] == 24'h000000; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_off;
    (!en)[*2] |-> !(pins_o.sck_oe || pins_o.sdo_oe || pins_o.sdi_func || pins_o.sel_func);
  endproperty
  a_off: assert property (p_off) else $error("disabled port owns pins");
  property p_sel; pins_o.sel_func |-> selen; endproperty
  a_sel: assert property (p_sel) else $error("select pin taken");
  property p_sckoe; (en && mode == MODE_SLAVE)[*2] |-> !pins_o.sck_oe; endproperty
  a_sckoe: assert property (p_sckoe) else $error("slave drives clock");
  property p_div4;
    en && mode == MODE_DIV4 && pins_o.sck_oe && $changed(pins_o.sck) |=> $stable(pins_o.sck);
  endproperty
  a_div4: assert property (p_div4) else $error("clock half period short");
  property p_always; (en && mode == MODE_SLAVE && !selen)[*2] |-> pins_o.sdo_oe; endproperty
  a_always: assert property (p_always) else $error("slave not selected");
  property p_float;
    (en && mode == MODE_SLAVE && selen && pins_i.sel_n)[*2] |-> !pins_o.sdo_oe;
  endproperty
  a_float: assert property (p_float) else $error("deselected slave drives");
endmodule
bind serial_port serial_port_checker u_serial_port_checker (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .pins_i(pins_i), .pins_o(pins_o));

/* verif/serial_port_tb.sv */
// self-checking testbench for the serial port block
`timescale 1ns/1ns
module serial_port_tb;
  import serial_port_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [3:0] adr_i = 4'h0, sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic ack_o, msdi, sub_clk_i = 1'b0, timer_match_i = 1'b0, run = 1'b0;
  logic tsck = 1'b1, tsdi = 1'b0, tsel = 1'b1, slv = 1'b0;
  logic load = 1'b0, pol = 1'b0, edg = 1'b0, ord = 1'b0;
  logic [7:0] tx = 8'h00, q, rx, cb, b, srx;
  pin_in_s pins_i;
  pin_out_s pins_o;
  int failures = 0, checks = 0;
  always #25 clk_i = ~clk_i;
  assign pins_i = {tsck, slv ? tsdi : msdi, tsel};
  // timer pulse every other cycle, sub clock changes with each pulse
  always @(posedge clk_i) begin
    timer_match_i <= run & ~timer_match_i;
    sub_clk_i <= sub_clk_i ^ timer_match_i;
  end
  serial_port u_serial_port (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .sub_clk_i(sub_clk_i), .timer_match_i(timer_match_i), .pins_i(pins_i), .pins_o(pins_o));
  serial_far_model u_serial_far_model (.clk_i(clk_i), .load_i(load), .tx_i(tx), .pol_i(pol),
    .edge_i(edg), .order_i(ord), .sck_i(pins_o.sck), .sck_oe_i(pins_o.sck_oe),
    .sdo_i(pins_o.sdo), .sdi_o(msdi), .rx_o(rx));
  task stop_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one classic wishbone cycle, held until ack is sampled
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h000000, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task rd(input string nm, input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, q, e);
  endtask
  // toggle the slave clock, two cycles per half period
  task edge2(input logic lvl);
    tsck <= lvl;
    repeat (2) @(posedge clk_i);
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    stop_test;
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("ctrl_a reset", ADDR_CTRL_A, {MODE_RESET, 5'h00});
    rd("ctrl_b reset", ADDR_CTRL_B, 8'h00);
    bus(1'b1, 4'hC, 8'hFF);
    rd("unmapped", 4'hC, 8'h00);
    // one byte in each master clock source, settings varied per pass
    for (int i = 0; i < 5; i++) begin
      cb = {2'b00, i[0], i[1], ~i[0], 3'b000};
      b = 8'h5A ^ (8'h33 * i[7:0]);
      run <= 1'b0;
      bus(1'b1, ADDR_CTRL_A, {i[2:0], 5'h02});
      bus(1'b1, ADDR_CTRL_B, cb);
      chk("idle pins", {6'h00, pins_o.sck, pins_o.sdo}, {6'h00, ~i[0], 1'b1});
      pol <= i[0];
      edg <= i[1];
      ord <= ~i[0];
      tx <= b;
      load <= 1'b1;
      @(posedge clk_i);
      load <= 1'b0;
      bus(1'b1, ADDR_DATA, ~b);
      bus(1'b1, ADDR_DATA, 8'h00);
      rd("collision", ADDR_CTRL_B, cb | 8'h02);
      run <= 1'b1;
      q = 8'h00;
      for (int k = 0; k < 400 && q[0] !== 1'b1; k++) bus(1'b0, ADDR_CTRL_B, 8'h00);
      rd("flags", ADDR_CTRL_B, cb | 8'h03);
      rd("rx data", ADDR_DATA, b);
      chk("far rx", rx, i[0] ? 8'({<<{~b}}) : ~b);
      bus(1'b1, ADDR_CTRL_B, cb);
    end
    slv <= 1'b1;
    bus(1'b1, ADDR_CTRL_A, {MODE_SLAVE, 5'h1F});
    rd("ctrl_a bits", ADDR_CTRL_A, {MODE_SLAVE, 5'h03});
    rd("sw incomplete", ADDR_CTRL_B, 8'h08);
    bus(1'b1, ADDR_CTRL_A, {MODE_SLAVE, 5'h02});
    bus(1'b1, ADDR_DATA, 8'h5A);
    chk("slave first", {7'h00, pins_o.sdo}, 8'h00);
    // slave byte, select pin unused, capture on rising clock
    for (int k = 0; k < 8; k++) begin
      tsdi <= 1'(8'h3C >> (7 - k));
      edge2(1'b0);
      srx = {srx[6:0], pins_o.sdo};
      edge2(1'b1);
    end
    repeat (3) @(posedge clk_i);
    rd("slave rx", ADDR_DATA, 8'h3C);
    chk("slave tx", srx, 8'h5A);
    rd("slave done", ADDR_CTRL_B, 8'h09);
    bus(1'b1, ADDR_CTRL_B, 8'h0C);
    tsel <= 1'b0;
    repeat (2) @(posedge clk_i);
    edge2(1'b0);
    edge2(1'b1);
    tsel <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd("incomplete", ADDR_CTRL_A, {MODE_SLAVE, 5'h03});
    rd("forced done", ADDR_CTRL_B, 8'h0D);
    stop_test;
  end
endmodule
